/* shared/shadow_data_pkg.sv */
package shadow_data_pkg;

  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  // Base of the sixteen aliased data slots; slot 2 sits at 0x50001138.
  localparam logic [31:0] SHADOW_BASE_ADDR  = 32'h50001130;
  localparam logic [31:0] SHADOW_SLOT2_ADDR = 32'h50001138;
  localparam int          SHADOW_SLOTS      = 16;
  // Control word: bit 0 fifo enable, bit 1 infrared mode.
  localparam logic [31:0] CTRL_ADDR         = 32'h50001170;
  // Line status word: rx data ready, overrun, tx holding empty.
  localparam logic [31:0] STATUS_ADDR       = 32'h50001174;
  localparam logic [15:0] SHADOW_RESET      = 16'h0000;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_FIFO_EN_BIT  = 0;
  localparam int CTRL_IR_MODE_BIT  = 1;
  localparam int LS_DATA_READY_BIT = 0;
  localparam int LS_OVERRUN_BIT    = 1;
  localparam int LS_THR_EMPTY_BIT  = 5;

  // ----------------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------------
  localparam int FIFO_DEPTH_DEFAULT = 16;
  localparam int DATA_W             = 8;

endpackage : shadow_data_pkg

/* hw/uart_shadow_data_port.sv */
`timescale 1ns/10ps
module uart_shadow_data_port
  import shadow_data_pkg::*;
#(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEFAULT
) (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // APB slave.
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [31:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Receiver side: bytes from the serial or infrared deserialiser.
  input  wire logic [7:0]  rx_serial_data_i,
  input  wire logic        rx_serial_valid_i,
  input  wire logic [7:0]  rx_ir_data_i,
  input  wire logic        rx_ir_valid_i,
  // Transmitter side: bytes to the serial or infrared serialiser.
  output logic      [7:0]  tx_data_o,
  output logic             tx_serial_valid_o,
  output logic             tx_ir_valid_o,
  input  wire logic        tx_serial_ready_i,
  input  wire logic        tx_ir_ready_i,
  // Status outputs.
  output logic             rx_data_ready_o,
  output logic             rx_overrun_o,
  output logic             tx_holding_empty_o
);

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  if (FIFO_DEPTH < 2 || FIFO_DEPTH > 256 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_chk
    $error("FIFO_DEPTH must be a power of two from 2 to 256");
  end

  localparam int AW = $clog2(FIFO_DEPTH);
  // Byte span covered by the aliased data slots.
  localparam logic [31:0] SLOT_SPAN = 32'(4 * SHADOW_SLOTS);

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  logic        fifo_en_q;
  logic        ir_mode_q;
  logic        overrun_q;
  logic        out_valid_q;
  logic [7:0]  out_data_q;
  logic        out_ir_q;

  // The access phase completes in its first cycle; no wait states.
  wire access_w   = psel_i & penable_i;
  // The alias window starts mid-way in a 64-byte block, so decode by offset from its base.
  wire [31:0] slot_off_w = paddr_i - SHADOW_BASE_ADDR;
  wire slot_hit_w = (slot_off_w < SLOT_SPAN) && (slot_off_w[1:0] == 2'b00);
  wire ctrl_hit_w = (paddr_i == CTRL_ADDR);
  wire stat_hit_w = (paddr_i == STATUS_ADDR);
  wire unmapped_w = ~(slot_hit_w | ctrl_hit_w | stat_hit_w);
  wire data_rd_w  = access_w & ~pwrite_i & slot_hit_w;
  wire data_wr_w  = access_w & pwrite_i & slot_hit_w;
  wire ctrl_wr_w  = access_w & pwrite_i & ctrl_hit_w;
  wire stat_rd_w  = access_w & ~pwrite_i & stat_hit_w;

  // ----------------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------------
  logic [7:0]  rx_mem_q [FIFO_DEPTH];
  logic [AW:0] rx_wp_q;
  logic [AW:0] rx_rp_q;
  logic [7:0]  rx_hold_q;
  logic        rx_hold_v_q;

  // Input selected by mode.
  wire [7:0] rx_byte_w  = ir_mode_q ? rx_ir_data_i : rx_serial_data_i;
  wire       rx_valid_w = ir_mode_q ? rx_ir_valid_i : rx_serial_valid_i;
  wire rx_empty_w = (rx_wp_q == rx_rp_q);
  wire rx_full_w  = (rx_wp_q[AW] != rx_rp_q[AW]) && (rx_wp_q[AW-1:0] == rx_rp_q[AW-1:0]);
  wire rx_ready_w = fifo_en_q ? ~rx_empty_w : rx_hold_v_q;
  wire rx_pop_w   = data_rd_w & fifo_en_q & ~rx_empty_w;
  wire rx_push_w  = rx_valid_w & fifo_en_q & ~rx_full_w;
  wire ovr_set_w  = rx_valid_w & (fifo_en_q ? rx_full_w : (rx_hold_v_q & ~data_rd_w));
  wire [7:0] rx_head_w = fifo_en_q ? rx_mem_q[rx_rp_q[AW-1:0]] : rx_hold_q;

  // Receive FIFO storage.
  always_ff @(posedge clk_i) begin
    if (rx_push_w) begin
      rx_mem_q[rx_wp_q[AW-1:0]] <= rx_byte_w;
    end
  end

  // Receive pointers and the single holding byte.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_wp_q     <= '0;
      rx_rp_q     <= '0;
      rx_hold_q   <= 8'h00;
      rx_hold_v_q <= 1'b0;
    end else begin
      if (rx_push_w) begin
        rx_wp_q <= rx_wp_q + 1'b1;
      end
      if (rx_pop_w) begin
        rx_rp_q <= rx_rp_q + 1'b1;
      end
      if (rx_valid_w & ~fifo_en_q) begin
        rx_hold_q   <= rx_byte_w;
        rx_hold_v_q <= 1'b1;
      end else if (data_rd_w & ~fifo_en_q) begin
        rx_hold_v_q <= 1'b0;
      end
    end
  end

  // Overrun flag: a new overrun wins over the clear by a status read.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      overrun_q <= 1'b0;
    end else if (ovr_set_w) begin
      overrun_q <= 1'b1;
    end else if (stat_rd_w) begin
      overrun_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------------
  logic [7:0]  tx_mem_q [FIFO_DEPTH];
  logic [AW:0] tx_wp_q;
  logic [AW:0] tx_rp_q;
  logic [7:0]  tx_hold_q;
  logic        tx_hold_v_q;

  wire tx_empty_w = (tx_wp_q == tx_rp_q);
  wire tx_full_w  = (tx_wp_q[AW] != tx_rp_q[AW]) && (tx_wp_q[AW-1:0] == tx_rp_q[AW-1:0]);
  wire tx_push_w  = data_wr_w & fifo_en_q & ~tx_full_w;
  wire src_v_w    = fifo_en_q ? ~tx_empty_w : tx_hold_v_q;
  wire [7:0] src_d_w = fifo_en_q ? tx_mem_q[tx_rp_q[AW-1:0]] : tx_hold_q;
  wire out_rdy_w  = out_ir_q ? tx_ir_ready_i : tx_serial_ready_i;
  // Output stage is a two-entry skid buffer so a receiver stall loses nothing.
  logic        skid_v_q;
  logic [7:0]  skid_d_q;
  wire take_w     = src_v_w & ~skid_v_q;
  wire thr_empty_w = fifo_en_q ? tx_empty_w : ~tx_hold_v_q;
  logic        tx_serial_valid_q;
  logic        tx_ir_valid_q;
  // Next state of the output register, so the pin valids can be flops of their own.
  wire out_load_w  = ~out_valid_q | out_rdy_w;
  wire out_valid_d = out_load_w ? (skid_v_q | take_w) : out_valid_q;
  wire out_ir_d    = out_load_w ? ir_mode_q : out_ir_q;

  // Transmit FIFO storage.
  always_ff @(posedge clk_i) begin
    if (tx_push_w) begin
      tx_mem_q[tx_wp_q[AW-1:0]] <= pwdata_i[7:0];
    end
  end

  // Transmit pointers and holding byte.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_wp_q     <= '0;
      tx_rp_q     <= '0;
      tx_hold_q   <= 8'h00;
      tx_hold_v_q <= 1'b0;
    end else begin
      if (tx_push_w) begin
        tx_wp_q <= tx_wp_q + 1'b1;
      end
      if (take_w & fifo_en_q) begin
        tx_rp_q <= tx_rp_q + 1'b1;
      end
      if (data_wr_w & ~fifo_en_q) begin
        tx_hold_q   <= pwdata_i[7:0];
        tx_hold_v_q <= 1'b1;
      end else if (take_w & ~fifo_en_q) begin
        tx_hold_v_q <= 1'b0;
      end
    end
  end

  // Skid entry and output register.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      out_valid_q <= 1'b0;
      out_data_q  <= 8'h00;
      out_ir_q    <= 1'b0;
      skid_v_q    <= 1'b0;
      skid_d_q    <= 8'h00;
      tx_serial_valid_q <= 1'b0;
      tx_ir_valid_q     <= 1'b0;
    end else begin
      if (take_w & out_valid_q & ~out_rdy_w) begin
        skid_v_q <= 1'b1;
        skid_d_q <= src_d_w;
      end else if (~out_valid_q | out_rdy_w) begin
        if (skid_v_q) begin
          out_valid_q <= 1'b1;
          out_data_q  <= skid_d_q;
          skid_v_q    <= 1'b0;
        end else begin
          out_valid_q <= take_w;
          out_data_q  <= take_w ? src_d_w : out_data_q;
        end
        out_ir_q <= ir_mode_q;
      end
      // Pin valids follow the output register's next state, one per mode.
      tx_serial_valid_q <= out_valid_d & ~out_ir_d;
      tx_ir_valid_q     <= out_valid_d & out_ir_d;
    end
  end

  // ----------------------------------------------------------------------
  // Registers and bus answer
  // ----------------------------------------------------------------------
  wire [31:0] status_w = {26'h0, thr_empty_w, 3'h0, overrun_q, rx_ready_w};
  wire [31:0] rd_mux_w = slot_hit_w ? {24'h0, rx_head_w} :
                         ctrl_hit_w ? {30'h0, ir_mode_q, fifo_en_q} :
                         stat_hit_w ? status_w : 32'h0;

  // Control register, APB read data and status outputs.
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      fifo_en_q          <= 1'b0;
      ir_mode_q          <= 1'b0;
      prdata_o           <= 32'h0;
      pready_o           <= 1'b0;
      pslverr_o          <= 1'b0;
      rx_data_ready_o    <= 1'b0;
      rx_overrun_o       <= 1'b0;
      tx_holding_empty_o <= 1'b1;
    end else begin
      if (ctrl_wr_w) begin
        fifo_en_q <= pwdata_i[CTRL_FIFO_EN_BIT];
        ir_mode_q <= pwdata_i[CTRL_IR_MODE_BIT];
      end
      pready_o           <= psel_i & ~penable_i;
      pslverr_o          <= psel_i & ~penable_i & unmapped_w;
      prdata_o           <= (psel_i & ~penable_i & ~pwrite_i) ? rd_mux_w : 32'h0;
      rx_data_ready_o    <= rx_ready_w;
      rx_overrun_o       <= overrun_q;
      tx_holding_empty_o <= thr_empty_w;
    end
  end

  // Transmit output pins, each straight from a flop.
  assign tx_data_o         = out_data_q;
  assign tx_serial_valid_o = tx_serial_valid_q;
  assign tx_ir_valid_o     = tx_ir_valid_q;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_full_arrival;
    fifo_en_q && rx_full_w && rx_valid_w;
  endsequence

  AST_RX_FULL_DROP: assert property (@(posedge clk_i) disable iff (reset_i)
    (s_full_arrival and !rx_pop_w) |=> $stable(rx_wp_q) && overrun_q)
    else $error("full receive FIFO accepted a byte");
  AST_TX_FULL_DROP: assert property (@(posedge clk_i) disable iff (reset_i)
    data_wr_w && fifo_en_q && tx_full_w |=> $stable(tx_wp_q))
    else $error("write to full transmit FIFO stored");
  AST_HOLD_OVR: assert property (@(posedge clk_i) disable iff (reset_i)
    !fifo_en_q && rx_hold_v_q && rx_valid_w && !data_rd_w |=> overrun_q && rx_hold_q == $past(rx_byte_w))
    else $error("holding overwrite missed overrun");
  AST_THR_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i)
    data_wr_w && !fifo_en_q && !ctrl_wr_w |=> !thr_empty_w || take_w)
    else $error("holding empty not cleared by write");
  AST_DR_OUT: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 rx_data_ready_o == $past(rx_ready_w))
    else $error("data ready output wrong");
  AST_UPPER_ZERO: assert property (@(posedge clk_i) disable iff (reset_i)
    pready_o && $past(slot_hit_w) |-> prdata_o[31:8] == 24'h0)
    else $error("upper data bits not zero");
  AST_TX_MODE: assert property (@(posedge clk_i) disable iff (reset_i)
    !(tx_serial_valid_o && tx_ir_valid_o))
    else $error("both transmit outputs active");
  AST_FIFO_COUNT: assert property (@(posedge clk_i) disable iff (reset_i)
    fifo_en_q && tx_full_w |-> (tx_wp_q - tx_rp_q) == (AW+1)'(FIFO_DEPTH))
    else $error("transmit FIFO full at wrong count");

  // Steps of a write into the single holding byte.
  sequence s_hold_write;
    data_wr_w && !fifo_en_q;
  endsequence

  sequence s_hold_stored;
    tx_hold_v_q && tx_hold_q == $past(pwdata_i[7:0]);
  endsequence

  // Steps of the first byte into an empty receive FIFO.
  sequence s_head_fill;
    fifo_en_q && rx_empty_w && rx_valid_w && !ctrl_wr_w;
  endsequence

  // Every word of the alias window answers at once and without error.
  AST_ALIAS_HIT: assert property (@(posedge clk_i) disable iff (reset_i)
    psel_i && !penable_i && paddr_i[1:0] == 2'b00 &&
    paddr_i >= SHADOW_BASE_ADDR && paddr_i < SHADOW_BASE_ADDR + SLOT_SPAN
    |=> pready_o && !pslverr_o)
    else $error("alias slot answered with an error");
  // The infrared receiver feeds the holding byte while infrared mode is on.
  AST_RX_IR_SELECT: assert property (@(posedge clk_i) disable iff (reset_i)
    !fifo_en_q && ir_mode_q && rx_ir_valid_i
    |=> rx_hold_v_q && rx_hold_q == $past(rx_ir_data_i))
    else $error("infrared byte not held");
  // The serial receiver feeds the holding byte in normal mode.
  AST_RX_SER_SELECT: assert property (@(posedge clk_i) disable iff (reset_i)
    !fifo_en_q && !ir_mode_q && rx_serial_valid_i
    |=> rx_hold_v_q && rx_hold_q == $past(rx_serial_data_i))
    else $error("serial byte not held");
  // A read of the holding byte with nothing arriving drops data ready.
  AST_RX_READ_CLEARS: assert property (@(posedge clk_i) disable iff (reset_i)
    !fifo_en_q && data_rd_w && !rx_valid_w && !ctrl_wr_w |=> !rx_ready_w)
    else $error("data ready stayed after read");
  // The first byte into an empty receive FIFO is at once its head.
  AST_RX_HEAD: assert property (@(posedge clk_i) disable iff (reset_i)
    s_head_fill |=> rx_head_w == $past(rx_byte_w))
    else $error("receive FIFO head wrong");
  // A write with the buffer off lands in the holding byte, the newest one winning.
  AST_HOLD_WRITE: assert property (@(posedge clk_i) disable iff (reset_i)
    s_hold_write |=> s_hold_stored)
    else $error("holding byte not written");
  // A stalled byte stays on the pins until the far side takes it.
  AST_TX_STALL_HOLD: assert property (@(posedge clk_i) disable iff (reset_i)
    (tx_serial_valid_o && !tx_serial_ready_i) || (tx_ir_valid_o && !tx_ir_ready_i)
    |=> $stable({tx_serial_valid_o, tx_ir_valid_o, tx_data_o}))
    else $error("stalled transmit byte changed");
  // Every setup cycle is answered in the next cycle.
  AST_PREADY_NEXT: assert property (@(posedge clk_i) disable iff (reset_i)
    psel_i && !penable_i |=> pready_o)
    else $error("setup cycle not answered");

endmodule : uart_shadow_data_port

/* dv/uart_far_end.sv */
`timescale 1ns/10ps
// ------------------------------------------------------------
// Far-end transceiver model
// ------------------------------------------------------------
module uart_far_end (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  // Bytes sent towards the port.
  output logic      [7:0] rx_data_o,
  output logic            rx_serial_valid_o,
  output logic            rx_ir_valid_o,
  // Bytes taken from the port.
  input  wire logic [7:0] tx_data_i,
  input  wire logic       tx_serial_valid_i,
  input  wire logic       tx_ir_valid_i,
  input  wire logic       stall_i,
  output logic            tx_ready_o
);
  logic [7:0] got[$];
  logic       got_ir[$];
  integer     seed = 32'h553641a7;

  // Lines start idle.
  initial begin
    rx_data_o = 8'h00;
    rx_serial_valid_o = 1'b0;
    rx_ir_valid_o = 1'b0;
    tx_ready_o = 1'b0;
  end

  // Ready is random, so acceptance is sometimes prompt and sometimes slow.
  always @(posedge clk_i) begin
    if (!reset_i && tx_ready_o && (tx_serial_valid_i || tx_ir_valid_i)) begin
      got.push_back(tx_data_i);
      got_ir.push_back(tx_ir_valid_i);
    end
    tx_ready_o <= !stall_i && $random(seed) % 3 != 0;
  end

  // One received byte; the data line shows the inverse once the pulse is over.
  task automatic send(input logic [7:0] b, input logic ir);
    @(posedge clk_i);
    rx_data_o <= b;
    rx_serial_valid_o <= !ir;
    rx_ir_valid_o <= ir;
    @(posedge clk_i);
    rx_serial_valid_o <= 1'b0;
    rx_ir_valid_o <= 1'b0;
    rx_data_o <= ~b;
  endtask : send
endmodule : uart_far_end

/* dv/test_uart_shadow_data_port.sv */
`timescale 1ns/10ps
module test_uart_shadow_data_port
  import shadow_data_pkg::*;
;
  localparam int DEPTH = 4;
  logic        clk_i, reset_i, psel, penable, pwrite, pready, pslverr, stall;
  logic [31:0] paddr, pwdata, prdata, r;
  logic [7:0]  rxd, txd, q[$];
  logic        rsv, riv, tsv, tiv, rdy, dr, ovr, tx_holding_empty, e;
  integer      seed = 32'h553641a7;
  int          bad_count = 0;
  int          num_checks = 0;
  int          n;

  uart_shadow_data_port #(.FIFO_DEPTH(DEPTH)) i_uart_shadow_data_port (
    .clk_i(clk_i), .reset_i(reset_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
    .pready_o(pready), .pslverr_o(pslverr), .rx_serial_data_i(rxd),
    .rx_serial_valid_i(rsv), .rx_ir_data_i(rxd), .rx_ir_valid_i(riv),
    .tx_data_o(txd), .tx_serial_valid_o(tsv), .tx_ir_valid_o(tiv),
    .tx_serial_ready_i(rdy), .tx_ir_ready_i(rdy), .rx_data_ready_o(dr),
    .rx_overrun_o(ovr), .tx_holding_empty_o(tx_holding_empty));

  uart_far_end i_far (
    .clk_i(clk_i), .reset_i(reset_i), .rx_data_o(rxd), .rx_serial_valid_o(rsv),
    .rx_ir_valid_o(riv), .tx_data_i(txd), .tx_serial_valid_i(tsv),
    .tx_ir_valid_i(tiv), .stall_i(stall), .tx_ready_o(rdy));

  // Clock at 20 MHz.
  always #25 clk_i = ~clk_i;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    num_checks++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED at %0t got %h expected %h", $time, g, x);
    end
  endtask : chk

  // One APB transfer; request held until pready is sampled high.
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_i);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin
      bad_count++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [31:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask : rdchk

  // Waits until the transmit path has emptied towards the far end.
  task automatic drain;
    int k = 0;
    repeat (4) @(posedge clk_i);
    while (!(tx_holding_empty === 1'b1 && tsv === 1'b0 && tiv === 1'b0) && k < 500) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 500) begin
      bad_count++;
      report_and_stop();
    end
  endtask : drain

  function automatic logic [31:0] stat(input logic d, input logic o, input logic t);
    stat = 32'h0;
    stat[LS_DATA_READY_BIT] = d;
    stat[LS_OVERRUN_BIT] = o;
    stat[LS_THR_EMPTY_BIT] = t;
  endfunction : stat

  // A random one of the sixteen aliases.
  function automatic logic [31:0] slot;
    slot = SHADOW_BASE_ADDR + 32'(4 * ($unsigned($random(seed)) % SHADOW_SLOTS));
  endfunction : slot

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    reset_i = 1'b1;
    {psel, penable, pwrite, stall} = 4'h0;
    paddr = 32'h0;
    pwdata = 32'h0;
    repeat (5) @(posedge clk_i);
    reset_i <= 1'b0;
    rdchk(STATUS_ADDR, stat(0, 0, 1));
    rdchk(CTRL_ADDR, 32'h0);
    apb(1'b0, 32'h50001200, 32'h0);
    chk({31'h0, e}, 32'h1);
    $display("reset and decode test done");
    for (int i = 0; i < DEPTH + 8; i++) q.push_back(8'($random(seed)));
    i_far.send(q[0], 1'b0);
    i_far.send(q[1], 1'b0);
    repeat (3) @(posedge clk_i);
    chk({30'h0, ovr, dr}, 32'h3);
    rdchk(STATUS_ADDR, stat(1, 1, 1));
    rdchk(slot(), {24'h0, q[1]});
    rdchk(STATUS_ADDR, stat(0, 0, 1));
    chk({30'h0, ovr, dr}, 32'h0);
    apb(1'b1, CTRL_ADDR, 32'h2);
    i_far.send(q[2], 1'b1);
    repeat (3) @(posedge clk_i);
    rdchk(slot(), {24'h0, q[2]});
    $display("receive without buffer test done");
    apb(1'b1, CTRL_ADDR, 32'h1);
    for (int i = 0; i <= DEPTH; i++) i_far.send(q[i], 1'b0);
    repeat (3) @(posedge clk_i);
    rdchk(STATUS_ADDR, stat(1, 1, 1));
    for (int i = 0; i < DEPTH; i++) rdchk(slot(), {24'h0, q[i]});
    rdchk(STATUS_ADDR, stat(0, 0, 1));
    $display("receive buffer test done");
    stall <= 1'b1;
    for (int i = 0; i < DEPTH + 8; i++) apb(1'b1, slot(), {24'($random(seed)), q[i]});
    rdchk(STATUS_ADDR, stat(0, 0, 0));
    stall <= 1'b0;
    drain();
    n = i_far.got.size();
    // The FIFO plus the two-entry output buffer hold DEPTH + 2 bytes.
    chk(32'(n), 32'(DEPTH + 2));
    for (int i = 0; i < n; i++) chk({i_far.got_ir[i], i_far.got[i]}, {1'b0, q[i]});
    $display("transmit buffer test done");
    apb(1'b1, CTRL_ADDR, 32'h0);
    i_far.got.delete();
    stall <= 1'b1;
    // Two bytes fill the output buffer, the third waits and the fourth replaces it.
    for (int i = 3; i < 7; i++) apb(1'b1, slot(), {24'h0, q[i]});
    rdchk(STATUS_ADDR, stat(0, 0, 0));
    stall <= 1'b0;
    drain();
    chk(32'(i_far.got.size()), 32'h3);
    chk({24'h0, i_far.got[0]}, {24'h0, q[3]});
    chk({24'h0, i_far.got[$]}, {24'h0, q[6]});
    apb(1'b1, CTRL_ADDR, 32'h3);
    i_far.got_ir.delete();
    chk({31'h0, tx_holding_empty}, 32'h1);
    apb(1'b1, slot(), {24'h0, q[5]});
    drain();
    chk({i_far.got_ir[$], i_far.got[$]}, {1'b1, q[5]});
    $display("transmit holding and infrared test done");
    report_and_stop();
  end
endmodule : test_uart_shadow_data_port
